//--- include/slc_consts.svh
// Purpose: Offsets, field positions, reset values and timing counts
// Assumes: Included by bare name
// Notes:   Definitions only
`ifndef SLC_CONSTS_SVH
`define SLC_CONSTS_SVH
// ****************************************
// Register offsets (byte addresses)
// ****************************************
`define SLC_OFS_CTRL     4'h0
`define SLC_OFS_STATUS   4'h4
`define SLC_OFS_CAPCNT   4'h8
// ****************************************
// Field positions and reset values
// ****************************************
`define SLC_CTRL_SEL_LSB 0
`define SLC_CTRL_SEL_MSB 3
`define SLC_CTRL_POL_BIT 4
`define SLC_CTRL_W       5
`define SLC_CTRL_RST     5'h00
`define SLC_CNT_W        16
`define SLC_GLOBAL_CLEAR_N_N_RST   1'b0
`define SLC_GLOBAL_PRESET_N_N_RST  1'b1
// ****************************************
// Pin synchroniser bit positions
// ****************************************
`define SLC_IN_FAST      0
`define SLC_IN_ROUTED    4
`define SLC_IN_USER      8
`define SLC_IN_EN        9
`define SLC_IN_SRC       10
`define SLC_IN_DIR       11
`define SLC_IN_ROUT      12
`define SLC_IN_CLR       13
`define SLC_IN_ASYNC_PRESET_N      14
`define SLC_IN_STRAP     15
`define SLC_SYNC_W       16
`define SLC_SYNC_RST     16'h6000
// ****************************************
// Timing
// ****************************************
`define SLC_CLK_NS       20
`define SLC_PWRUP_NS     320
`define SLC_STRAP_WAIT   4
`endif

//--- include/slc_flop_if.sv
// Purpose: Carries capture control between the cell and its storage bit
// Assumes: Single clock domain
// Notes:   None
`timescale 1ns/1ps
interface slc_flop_if;
  logic capture;
  logic dIn;
  logic clearAct;
  logic presetAct;
  logic q;
  modport drv  (output capture, output dIn, output clearAct, output presetAct, input q);
  modport flop (input capture, input dIn, input clearAct, input presetAct, output q);
endinterface

//--- include/slc_pkg.sv
// Purpose: Types shared by the sequential cell files
// Assumes: Nothing
// Notes:   Constants live in slc_consts.svh
package slc_pkg;
  typedef enum logic [3:0] {
    SRC_FAST0   = 4'h0,
    SRC_FAST1   = 4'h1,
    SRC_FAST2   = 4'h2,
    SRC_FAST3   = 4'h3,
    SRC_ROUTED0 = 4'h4,
    SRC_ROUTED1 = 4'h5,
    SRC_ROUTED2 = 4'h6,
    SRC_ROUTED3 = 4'h7,
    SRC_USER    = 4'h8
  } slc_clk_src_t;
  typedef enum logic [1:0] {
    ST_STRAP = 2'b00,
    ST_PWRUP = 2'b01,
    ST_USER  = 2'b10
  } slc_pwr_state_t;
endpackage

//--- src/slc_cell.sv
// How it works
// - Active-low local clear forces the stored bit to zero, ignoring the cell clock.
// - Active-low local preset forces the stored bit to one, ignoring the cell clock.
// - With clear and preset both low, clear wins and the bit stays zero.
// - Data enable decides whether an active edge captures new data.
// - Direct data input comes from the adjacent cell with no added stage.
// - A routable data input also exists, muxed two-to-one with the direct one.
// - Source select high takes the direct input instead of the routable one.
// - Clock is one of four fast, four routed or a user clock; polarity selectable.
// - Global clear and preset act on every flop of the device at once.
// - At power-up globals are clear 0, preset 1; strap option swaps them.
// - In user mode both global lines are held high and inactive.
//
// Purpose: Configurable flip-flop cell emulated on the system clock
// Assumes: Fabric pins and cell clocks are asynchronous to mclk
// Notes:   Avalon-MM slave, one wait state on every access
`timescale 1ns/1ps
`include "slc_consts.svh"
module slc_cell #(
  parameter int POWERUP_CYCLES =
    (`SLC_PWRUP_NS + `SLC_CLK_NS - 1) / `SLC_CLK_NS
) (
  input  wire logic        mclk,
  input  wire logic        reset_n,
  input  wire logic [3:0]  address,
  input  wire logic [3:0]  byteenable,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [31:0] writedata,
  output      logic [31:0] readdata,
  output      logic        waitrequest,
  input  wire logic [3:0]  fastClk,
  input  wire logic [3:0]  routedClk,
  input  wire logic        userClk,
  input  wire logic        dataEnableIn,
  input  wire logic        sourceSelect,
  input  wire logic        directDataIn,
  input  wire logic        routableDataIn,
  input  wire logic        asyncClearN,
  input  wire logic        asyncPresetN,
  input  wire logic        globalSetStrap,
  output      logic        cellQ,
  output      logic        globalClearN,
  output      logic        globalPresetN
);
  import slc_pkg::*;
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  localparam int CW = `SLC_CNT_W;
  localparam int SW = `SLC_SYNC_W;

  // ****************************************
  // Functions
  // ****************************************
  function automatic logic pick_clock(
    input slc_clk_src_t        sel,
    input logic [SW-1:0]       lv
  );
    logic r;
    r = 1'b0;
    case (sel)
      SRC_FAST0:   r = lv[`SLC_IN_FAST];
      SRC_FAST1:   r = lv[`SLC_IN_FAST + 1];
      SRC_FAST2:   r = lv[`SLC_IN_FAST + 2];
      SRC_FAST3:   r = lv[`SLC_IN_FAST + 3];
      SRC_ROUTED0: r = lv[`SLC_IN_ROUTED];
      SRC_ROUTED1: r = lv[`SLC_IN_ROUTED + 1];
      SRC_ROUTED2: r = lv[`SLC_IN_ROUTED + 2];
      SRC_ROUTED3: r = lv[`SLC_IN_ROUTED + 3];
      SRC_USER:    r = lv[`SLC_IN_USER];
      default:     r = 1'b0;
    endcase
    return r;
  endfunction

  function automatic logic reg_hit(
    input logic [3:0] addr,
    input logic [3:0] ofs
  );
    return addr == ofs;
  endfunction

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [SW-1:0] pinRaw;
  logic [SW-1:0] syncS1R;
  logic [SW-1:0] syncS2R;
  logic [SW-1:0] syncS3R;
  logic [SW-1:0] accR;

  assign pinRaw = {globalSetStrap, asyncPresetN, asyncClearN, routableDataIn,
                   directDataIn, sourceSelect, dataEnableIn, userClk,
                   routedClk, fastClk};

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      syncS1R <= `SLC_SYNC_RST;
      syncS2R <= `SLC_SYNC_RST;
      syncS3R <= `SLC_SYNC_RST;
    end else begin
      syncS1R <= pinRaw;
      syncS2R <= syncS1R;
      syncS3R <= syncS2R;
    end
  end

  // A change is taken only where stages two and three agree, so a
  // metastable settle cannot fake a cell clock edge
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      accR <= `SLC_SYNC_RST;
    end else begin
      for (int i = 0; i < SW; i++) begin
        if (syncS2R[i] == syncS3R[i]) begin
          accR[i] <= syncS3R[i];
        end
      end
    end
  end

  logic enAcc;
  logic srcAcc;
  logic dirAcc;
  logic routAcc;
  logic clrAccN;
  logic psetAccN;

  assign enAcc    = accR[`SLC_IN_EN];
  assign srcAcc   = accR[`SLC_IN_SRC];
  assign dirAcc   = accR[`SLC_IN_DIR];
  assign routAcc  = accR[`SLC_IN_ROUT];
  assign clrAccN  = accR[`SLC_IN_CLR];
  assign psetAccN = accR[`SLC_IN_ASYNC_PRESET_N];

  // ****************************************
  // Control register and clock selection
  // ****************************************
  logic [`SLC_CTRL_W-1:0] ctrlR;
  slc_clk_src_t           clkSel;
  logic                   clkPol;
  logic                   clkLvl;
  logic                   clkPrevR;
  logic                   activeEdge;

  assign clkSel = slc_clk_src_t'(ctrlR[`SLC_CTRL_SEL_MSB:`SLC_CTRL_SEL_LSB]);
  assign clkPol = ctrlR[`SLC_CTRL_POL_BIT];
  assign clkLvl = pick_clock(clkSel, accR);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      clkPrevR <= 1'b0;
    end else begin
      clkPrevR <= clkLvl;
    end
  end

  // Polarity low takes the rising edge, high the falling edge
  assign activeEdge = clkPol ? (clkPrevR & ~clkLvl) : (~clkPrevR & clkLvl);

  // ****************************************
  // Power-up sequencer and global lines
  // ****************************************
  slc_pwr_state_t pwrR;
  slc_pwr_state_t pwrNxt;
  logic [CW-1:0]  pwrCntR;
  logic [CW-1:0]  pwrCntNxt;
  logic           optR;
  logic           optNxt;

  always_comb begin
    pwrNxt    = pwrR;
    pwrCntNxt = pwrCntR + 1'b1;
    optNxt    = optR;
    case (pwrR)
      ST_STRAP: begin
        // Strap is read only after it has crossed the synchroniser
        if (pwrCntR == CW'(`SLC_STRAP_WAIT)) begin
          optNxt    = accR[`SLC_IN_STRAP];
          pwrNxt    = ST_PWRUP;
          pwrCntNxt = '0;
        end
      end
      ST_PWRUP: begin
        if (pwrCntR == CW'(POWERUP_CYCLES - 1)) begin
          pwrNxt    = ST_USER;
          pwrCntNxt = '0;
        end
      end
      ST_USER: begin
        pwrCntNxt = pwrCntR;
      end
      default: begin
        pwrNxt    = ST_STRAP;
        pwrCntNxt = '0;
      end
    endcase
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      pwrR    <= ST_STRAP;
      pwrCntR <= '0;
    end else begin
      pwrR    <= pwrNxt;
      pwrCntR <= pwrCntNxt;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      optR <= 1'b0;
    end else begin
      optR <= optNxt;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      globalClearN  <= `SLC_GLOBAL_CLEAR_N_N_RST;
      globalPresetN <= `SLC_GLOBAL_PRESET_N_N_RST;
    end else if (pwrNxt == ST_USER) begin
      globalClearN  <= 1'b1;
      globalPresetN <= 1'b1;
    end else if (pwrNxt == ST_PWRUP) begin
      globalClearN  <= optNxt;
      globalPresetN <= ~optNxt;
    end else begin
      globalClearN  <= `SLC_GLOBAL_CLEAR_N_N_RST;
      globalPresetN <= `SLC_GLOBAL_PRESET_N_N_RST;
    end
  end

  // ****************************************
  // Storage bit
  // ****************************************
  slc_flop_if fl ();

  // Direct input adds no stage over the routable one
  assign fl.dIn       = srcAcc ? dirAcc : routAcc;
  assign fl.capture   = activeEdge & enAcc;
  // Globals feed the same clear and preset path as the local pins
  assign fl.clearAct  = ~clrAccN | ~globalClearN;
  assign fl.presetAct = ~psetAccN | ~globalPresetN;

  slc_flop u_flop (
    .mclk    (mclk),
    .reset_n (reset_n),
    .fl      (fl)
  );

  assign cellQ = fl.q;

  // ****************************************
  // Capture counter
  // ****************************************
  logic [CW-1:0] capCntR;
  logic          busWr;
  logic          busRd;
  logic          ackR;

  assign busWr = write & ackR & (byteenable != 4'h0);
  assign busRd = read & ~ackR;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      capCntR <= '0;
    end else if (fl.capture) begin
      // A capture in the clearing cycle still counts
      if (busWr && reg_hit(address, `SLC_OFS_CAPCNT)) begin
        capCntR <= CW'(1);
      end else begin
        capCntR <= capCntR + 1'b1;
      end
    end else if (busWr && reg_hit(address, `SLC_OFS_CAPCNT)) begin
      capCntR <= '0;
    end
  end

  // ****************************************
  // Avalon-MM slave
  // ****************************************
  // Every access waits one cycle so read data can come from a flop
  assign waitrequest = (read | write) & ~ackR;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ackR <= 1'b0;
    end else begin
      ackR <= (read | write) & ~ackR;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrlR <= `SLC_CTRL_RST;
    end else if (busWr && byteenable[0] && reg_hit(address, `SLC_OFS_CTRL)) begin
      ctrlR <= writedata[`SLC_CTRL_W-1:0];
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      readdata <= '0;
    end else if (busRd) begin
      if (reg_hit(address, `SLC_OFS_CTRL)) begin
        readdata <= {{(32 - `SLC_CTRL_W){1'b0}}, ctrlR};
      end else if (reg_hit(address, `SLC_OFS_STATUS)) begin
        readdata <= {25'h0, srcAcc, enAcc, globalPresetN, globalClearN,
                     optR, pwrR == ST_USER, fl.q};
      end else if (reg_hit(address, `SLC_OFS_CAPCNT)) begin
        readdata <= {{(32 - CW){1'b0}}, capCntR};
      end else begin
        readdata <= '0;
      end
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  a_clear_forces_zero: assert property (
    !clrAccN |=> !cellQ)
    else $error("local clear did not zero the bit");
  a_preset_forces_one: assert property (
    !psetAccN && clrAccN && globalClearN |=> cellQ)
    else $error("local preset did not set the bit");
  a_clear_beats_preset: assert property (
    fl.clearAct && fl.presetAct |=> !cellQ)
    else $error("preset won over clear");
  a_enable_captures: assert property (
    activeEdge && enAcc && !fl.clearAct && !fl.presetAct
      |=> cellQ == $past(fl.dIn))
    else $error("enabled edge did not capture data");
  a_direct_path: assert property (
    fl.capture && srcAcc && !fl.clearAct && !fl.presetAct
      |=> cellQ == $past(dirAcc))
    else $error("direct input not taken with select high");
  a_routable_path: assert property (
    fl.capture && !srcAcc && !fl.clearAct && !fl.presetAct
      |=> cellQ == $past(routAcc))
    else $error("routable input not taken with select low");
  a_edge_polarity: assert property (
    activeEdge |-> clkLvl != clkPol && $past(clkLvl) == clkPol)
    else $error("capture on the wrong clock edge");
  a_disabled_holds: assert property (
    activeEdge && !enAcc && !fl.clearAct && !fl.presetAct
      |=> $stable(cellQ))
    else $error("bit changed with data enable low");
  a_global_clear: assert property (
    !globalClearN |=> !cellQ)
    else $error("global clear did not zero the bit");
  a_powerup_levels: assert property (
    pwrR == ST_PWRUP |-> globalClearN == optR && globalPresetN == !optR)
    else $error("wrong global levels during power-up");
  a_user_mode_high: assert property (
    pwrR == ST_USER |-> globalClearN && globalPresetN)
    else $error("global line active in user mode");
  a_powerup_length: assert property (
    $rose(pwrR == ST_PWRUP) |-> ##[1:300] pwrR == ST_USER)
    else $error("power-up phase did not end");
endmodule

//--- src/slc_flop.sv
// Purpose: The storage bit of the cell
// Assumes: Clear and preset already qualified by the caller
// Notes:   Clear beats preset beats capture
`timescale 1ns/1ps
module slc_flop (
  input  wire logic mclk,
  input  wire logic reset_n,
  slc_flop_if.flop  fl
);
  import slc_pkg::*;
  default clocking cbf @(posedge mclk);
  endclocking
  default disable iff (!reset_n);

  logic qR;

  assign fl.q = qR;

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      qR <= 1'b0;
    end else if (fl.clearAct) begin
      qR <= 1'b0;
    end else if (fl.presetAct) begin
      qR <= 1'b1;
    end else if (fl.capture) begin
      qR <= fl.dIn;
    end
    // No capture: bit holds its value
  end

  a_hold_when_idle: assert property (
    !fl.clearAct && !fl.presetAct && !fl.capture |=> qR == $past(qR))
    else $error("storage bit changed with nothing acting on it");
endmodule

//--- test/slc_fabric_model.sv
// Purpose: Fabric and adjacent logic cell that feed the sequential cell pins
// Assumes: Bench moves the request levels just after an mclk edge
// Notes:   Unpicked clock lines stay low
`timescale 1ns/1ps
module slc_fabric_model (
  input  wire logic [3:0] clkPick,
  input  wire logic       clkLevel,
  input  wire logic       enReq,
  input  wire logic       selReq,
  input  wire logic       dirReq,
  input  wire logic       routReq,
  input  wire logic       clrReqN,
  input  wire logic       psetReqN,
  output      logic [3:0] fastClk,
  output      logic [3:0] routedClk,
  output      logic       userClk,
  output      logic       dataEnableIn,
  output      logic       sourceSelect,
  output      logic       directDataIn,
  output      logic       routableDataIn,
  output      logic       asyncClearN,
  output      logic       asyncPresetN
);
  // ****
  // Clock nets
  // ****
  // Only the picked line moves, so reselecting while clkLevel is low never makes a stray edge
  always_comb begin
    fastClk   = 4'h0;
    routedClk = 4'h0;
    userClk   = 1'b0;
    if (clkPick < 4'h4) begin
      fastClk[clkPick[1:0]] = clkLevel;
    end else if (clkPick < 4'h8) begin
      routedClk[clkPick[1:0]] = clkLevel;
    end else if (clkPick == 4'h8) begin
      userClk = clkLevel;
    end
  end
  // ****
  // Control and data from ordinary user logic
  // ****
  assign dataEnableIn   = enReq;
  assign sourceSelect   = selReq;
  assign asyncClearN    = clrReqN;
  assign asyncPresetN   = psetReqN;
  assign directDataIn   = dirReq;
  assign routableDataIn = routReq;
endmodule

//--- test/testbench.sv
// Purpose: Self-checking bench for the sequential cell
// Assumes: Pins settle within the synchroniser latency of the cell
// Notes:   Short power-up count keeps the run brief
`timescale 1ns/1ps
`include "slc_consts.svh"
module testbench;
  typedef struct packed {
    logic [3:0] src;
    logic [5:0] bits;
  } slc_row_t;
  logic        mclk;
  logic        reset_n;
  logic [3:0]  address;
  logic [3:0]  byteenable;
  logic        read;
  logic        write;
  logic [31:0] writedata;
  logic [31:0] readdata;
  logic        waitrequest;
  logic [3:0]  fastClk;
  logic [3:0]  routedClk;
  logic        userClk;
  logic        dataEnableIn;
  logic        sourceSelect;
  logic        directDataIn;
  logic        routableDataIn;
  logic        asyncClearN;
  logic        asyncPresetN;
  logic        globalSetStrap;
  logic        cellQ;
  logic        globalClearN;
  logic        globalPresetN;
  logic [3:0]  clkPick;
  logic        clkLevel;
  logic        enReq;
  logic        selReq;
  logic        dirReq;
  logic        routReq;
  logic        clrReqN;
  logic        psetReqN;
  logic [31:0] rd;
  int          failCount;
  int          checked;
  // Bits: polarity, enable, select, direct, routable, expected bit
  slc_row_t rows [11] = '{{4'h0, 6'h1d}, {4'h1, 6'h34}, {4'h2, 6'h1f}, {4'h3, 6'h29},
    {4'h4, 6'h13}, {4'h5, 6'h3a}, {4'h6, 6'h06}, {4'h7, 6'h33}, {4'h8, 6'h1a},
    {4'h8, 6'h33}, {4'h9, 6'h19}};
  slc_cell #(.POWERUP_CYCLES(8)) i_slc_cell (.mclk(mclk), .reset_n(reset_n),
    .address(address), .byteenable(byteenable), .read(read), .write(write),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .fastClk(fastClk), .routedClk(routedClk), .userClk(userClk),
    .dataEnableIn(dataEnableIn), .sourceSelect(sourceSelect),
    .directDataIn(directDataIn), .routableDataIn(routableDataIn),
    .asyncClearN(asyncClearN), .asyncPresetN(asyncPresetN),
    .globalSetStrap(globalSetStrap), .cellQ(cellQ), .globalClearN(globalClearN),
    .globalPresetN(globalPresetN));
  slc_fabric_model i_slc_fabric_model (.clkPick(clkPick), .clkLevel(clkLevel),
    .enReq(enReq), .selReq(selReq), .dirReq(dirReq), .routReq(routReq),
    .clrReqN(clrReqN), .psetReqN(psetReqN), .fastClk(fastClk),
    .routedClk(routedClk), .userClk(userClk), .dataEnableIn(dataEnableIn),
    .sourceSelect(sourceSelect), .directDataIn(directDataIn),
    .routableDataIn(routableDataIn), .asyncClearN(asyncClearN),
    .asyncPresetN(asyncPresetN));
  // ****
  // Clock and tasks
  // ****
  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      failCount++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic finishTest();
    if (failCount == 0 && checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic waitClk(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // Request held until waitrequest is seen low at an edge
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd,
                     output logic [31:0] data);
    @(posedge mclk);
    address   <= a;
    writedata <= wd;
    write     <= wr;
    read      <= ~wr;
    // Only the watchdog ends a wait that never completes
    do begin
      @(posedge mclk);
    end while (waitrequest !== 1'b0);
    data = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask
  task automatic doReset(input logic strap);
    globalSetStrap <= strap;
    reset_n        <= 1'b0;
    waitClk(16);
    chk("q in reset", 32'h0, {31'h0, cellQ});
    chk("global_clear_n in reset", 32'h0, {31'h0, globalClearN});
    reset_n <= 1'b1;
    waitClk(7);
    chk("global_clear_n pwrup", {31'h0, strap}, {31'h0, globalClearN});
    chk("global_preset_n pwrup", {31'h0, ~strap}, {31'h0, globalPresetN});
    waitClk(20);
    chk("globals user", 32'h3, {30'h0, globalClearN, globalPresetN});
    chk("q after pwrup", {31'h0, strap}, {31'h0, cellQ});
    bus(1'b0, `SLC_OFS_STATUS, 32'h0, rd);
    chk("status", {25'h0, selReq, enReq, 2'h3, strap, 1'b1, strap}, rd);
  endtask
  // ****
  // Main sequence
  // ****
  initial begin
    reset_n = 1'b0;
    address = 4'h0;
    byteenable = 4'hf;
    read = 1'b0;
    write = 1'b0;
    writedata = 32'h0;
    globalSetStrap = 1'b0;
    clkPick = 4'h0;
    clkLevel = 1'b0;
    enReq = 1'b0;
    selReq = 1'b0;
    dirReq = 1'b0;
    routReq = 1'b0;
    clrReqN = 1'b1;
    psetReqN = 1'b1;
    failCount = 0;
    checked = 0;
    doReset(1'b0);
    bus(1'b0, `SLC_OFS_CTRL, 32'h0, rd);
    chk("ctrl reset", {27'h0, `SLC_CTRL_RST}, rd);
    bus(1'b1, 4'hc, 32'hffff_ffff, rd);
    bus(1'b0, 4'hc, 32'h0, rd);
    chk("unmapped", 32'h0, rd);
    for (int i = 0; i < 11; i++) begin
      clkPick  <= rows[i].src;
      clkLevel <= 1'b0;
      waitClk(6);
      bus(1'b1, `SLC_OFS_CTRL, {27'h0, rows[i].bits[5], rows[i].src}, rd);
      clkLevel <= rows[i].bits[5];
      enReq    <= rows[i].bits[4];
      selReq   <= rows[i].bits[3];
      dirReq   <= rows[i].bits[2];
      routReq  <= rows[i].bits[1];
      waitClk(6);
      clkLevel <= ~rows[i].bits[5];
      waitClk(6);
      chk("cellQ", {31'h0, rows[i].bits[0]}, {31'h0, cellQ});
      // Enable drops in the same cycle as the clock returns, and the return edge is the inactive one, so it never counts
      clkLevel <= rows[i].bits[5];
      enReq    <= 1'b0;
      waitClk(6);
    end
    bus(1'b0, `SLC_OFS_CTRL, 32'h0, rd);
    chk("ctrl", 32'h9, rd);
    bus(1'b0, `SLC_OFS_CAPCNT, 32'h0, rd);
    chk("captures", 32'h8, rd);
    bus(1'b1, `SLC_OFS_CAPCNT, 32'h0, rd);
    bus(1'b0, `SLC_OFS_CAPCNT, 32'h0, rd);
    chk("captures clr", 32'h0, rd);
    clrReqN <= 1'b0;
    waitClk(6);
    chk("clear", 32'h0, {31'h0, cellQ});
    psetReqN <= 1'b0;
    waitClk(6);
    chk("both low", 32'h0, {31'h0, cellQ});
    clrReqN <= 1'b1;
    waitClk(6);
    chk("preset", 32'h1, {31'h0, cellQ});
    psetReqN <= 1'b1;
    waitClk(6);
    chk("preset gone", 32'h1, {31'h0, cellQ});
    clrReqN <= 1'b0;
    waitClk(6);
    clrReqN <= 1'b1;
    doReset(1'b1);
    finishTest();
  end
  initial begin
    #200000;
    failCount++;
    finishTest();
  end
endmodule
